// ==== design/cmplat_top.sv ====
// Comparator power control and latched trip status register bank
//
// Operation
// RQ1: Power register bits 18:0, reset zero.
// RQ2: Power bit one runs comparator, zero shuts.
// RQ3: Latch each trip; read back at 0x328. Code ignores trips of comparators whose power bit is zero.
// RQ4: Write one clears latch; zero keeps.
// RQ5: Latch holds until software clears it.
// RQ6: Bits 18 to 8 map same index.
// RQ7: Bits 7 to 0 behave the same.
// RQ8: Bits 31:19 read zero, ignore writes.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
module cmplat_top
  import cmplat_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire cmplat_pkg::cmplat_req_t bus_req,
  output cmplat_pkg::cmplat_rsp_t bus_rsp,
  input wire logic [cmplat_pkg::CMP_COUNT-1:0] trip_in,
  output logic [cmplat_pkg::CMP_COUNT-1:0] cmp_power_on,
  output logic [cmplat_pkg::CMP_COUNT-1:0] cmp_irq_level,
  output logic irq
);
  import cmplat_pkg::*;

  logic [CMP_COUNT-1:0] pwr_reg;
  logic [CMP_COUNT-1:0] latch_reg;
  logic [CMP_COUNT-1:0] latch_next;
  logic [CMP_COUNT-1:0] sts_reg;
  logic [CMP_COUNT-1:0] sts_next;
  logic [CMP_COUNT-1:0] mask_reg;
  logic [CMP_COUNT-1:0] trip_prev_reg;
  logic [CMP_COUNT-1:0] wmask;
  logic [CMP_COUNT-1:0] wdata;
  logic [CMP_COUNT-1:0] rise;
  logic [31:0] rdata_next;
  cmplat_state_t state_reg;
  logic wr_go;
  logic rd_go;

  // Expand byte enables to the live low 19 bits; upper bits never stored
  function automatic logic [CMP_COUNT-1:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return m[CMP_COUNT-1:0];
  endfunction

  function automatic logic [31:0] zext(input logic [CMP_COUNT-1:0] v);
    return {{(32-CMP_COUNT){1'b0}}, v};
  endfunction

  // One wait state per access: registered readdata, waitrequest low once.
  // Writes land at the edge where the master sees waitrequest low.
  assign wr_go = bus_req.write && state_reg == CMPLAT_DONE;
  assign rd_go = bus_req.read && state_reg == CMPLAT_IDLE;
  assign wmask = be_mask(bus_req.byteenable);
  assign wdata = bus_req.writedata[CMP_COUNT-1:0]; // RQ8
  assign rise = trip_in & ~trip_prev_reg & pwr_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= CMPLAT_IDLE;
    end else begin
      case (state_reg)
        CMPLAT_IDLE: begin
          if (bus_req.read || bus_req.write) begin
            state_reg <= CMPLAT_DONE;
          end
        end
        CMPLAT_DONE: state_reg <= CMPLAT_IDLE;
        default: state_reg <= CMPLAT_IDLE;
      endcase
    end
  end

  // Both response fields share one process; the struct is one variable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rsp.waitrequest <= 1'b1;
      bus_rsp.readdata <= '0;
    end else begin
      bus_rsp.waitrequest <= !((bus_req.read || bus_req.write) &&
                               state_reg == CMPLAT_IDLE);
      if (rd_go) begin
        bus_rsp.readdata <= rdata_next;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_reg <= RST_PWR; // RQ1
    end else if (wr_go && bus_req.address == OFF_PWR) begin
      pwr_reg <= (pwr_reg & ~wmask) | (wdata & wmask); // RQ1
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_reg <= RST_MASK;
    end else if (wr_go && bus_req.address == OFF_IRQ_MASK) begin
      mask_reg <= (mask_reg & ~wmask) | (wdata & wmask);
    end
  end

  // Edge of the trip only; a comparator held tripped does not re-fire
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trip_prev_reg <= '0;
    end else begin
      trip_prev_reg <= trip_in;
    end
  end

  // Set wins over a clear in the same cycle so no trip is lost
  always_comb begin
    latch_next = latch_reg;
    if (wr_go && bus_req.address == OFF_STAT) begin
      latch_next = latch_reg & ~(wdata & wmask); // RQ4 RQ6 RQ7
    end
    latch_next = latch_next | rise; // RQ3 RQ5
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_reg <= RST_STAT; // RQ4
    end else begin
      latch_reg <= latch_next;
    end
  end

  // Sticky event status, cleared by reading it
  always_comb begin
    sts_next = sts_reg;
    if (rd_go && bus_req.address == OFF_IRQ_STATUS) begin
      sts_next = '0;
    end
    sts_next = sts_next | rise;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sts_reg <= '0;
    end else begin
      sts_reg <= sts_next;
    end
  end

  always_comb begin
    case (bus_req.address)
      OFF_PWR: rdata_next = zext(pwr_reg); // RQ8
      OFF_STAT: rdata_next = zext(latch_reg); // RQ3 RQ8
      OFF_IRQ_STATUS: rdata_next = zext(sts_reg);
      OFF_IRQ_MASK: rdata_next = zext(mask_reg);
      default: rdata_next = UNMAPPED_DATA;
    endcase
  end

  // Power enables reach the analog macros through one register stage, a cycle after pwr_reg
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmp_power_on <= '0;
    end else begin
      cmp_power_on <= pwr_reg; // RQ2
    end
  end

  // Per-comparator interrupt follows its latch; no new one until cleared
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmp_irq_level <= '0;
      irq <= 1'b0;
    end else begin
      cmp_irq_level <= latch_next; // RQ5
      irq <= |(sts_next & mask_reg);
    end
  end

  property p_pwr_write;
    @(posedge clk_sys) disable iff (rst)
      (wr_go && bus_req.address == OFF_PWR && bus_req.byteenable == 4'hF)
      |-> ##2 cmp_power_on == bus_req.writedata[CMP_COUNT-1:0] ||
          $past(bus_req.writedata[CMP_COUNT-1:0], 2) == cmp_power_on;
  endproperty
  a_pwr_write: assert property (p_pwr_write) // RQ1
    else $error("Power write did not reach outputs");

  property p_pwr_out;
    @(posedge clk_sys) disable iff (rst)
      ##1 cmp_power_on == $past(pwr_reg);
  endproperty
  a_pwr_out: assert property (p_pwr_out) // RQ2
    else $error("Power output does not follow register");

  property p_trip_sets;
    @(posedge clk_sys) disable iff (rst)
      |rise |-> ##1 ((latch_reg & $past(rise)) == $past(rise));
  endproperty
  a_trip_sets: assert property (p_trip_sets) // RQ3
    else $error("Trip edge not latched");

  property p_clear_one;
    @(posedge clk_sys) disable iff (rst)
      (wr_go && bus_req.address == OFF_STAT && rise == '0 &&
       bus_req.byteenable == 4'hF)
      |=> (latch_reg & $past(wdata)) == '0;
  endproperty
  a_clear_one: assert property (p_clear_one) // RQ4
    else $error("Write of one did not clear latch");

  sequence s_no_clear;
    !(wr_go && bus_req.address == OFF_STAT);
  endsequence

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
      s_no_clear |=> (latch_reg & $past(latch_reg)) == $past(latch_reg);
  endproperty
  a_hold: assert property (p_hold) // RQ5
    else $error("Latch dropped without a clear");

  property p_zero_keeps;
    @(posedge clk_sys) disable iff (rst)
      (wr_go && bus_req.address == OFF_STAT && rise == '0)
      |=> (latch_reg & ~$past(wdata)) == ($past(latch_reg) & ~$past(wdata));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) // RQ6
    else $error("Write of zero changed latch");

  property p_low_bits;
    @(posedge clk_sys) disable iff (rst)
      (rise[7:0] != 8'h00) |=> cmp_irq_level[7:0] != 8'h00;
  endproperty
  a_low_bits: assert property (p_low_bits) // RQ7
    else $error("Low comparator trip not latched");

  property p_upper_zero;
    @(posedge clk_sys) disable iff (rst)
      (rd_go && (bus_req.address == OFF_PWR || bus_req.address == OFF_STAT))
      |=> bus_rsp.readdata[31:CMP_COUNT] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) // RQ8
    else $error("Reserved bits read nonzero");
endmodule // cmplat_top

// ==== inc/cmplat_pkg.sv ====
// Package for the comparator power and status latch block
package cmplat_pkg;
  localparam int unsigned CMP_COUNT = 19;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_PWR = 12'h30C;
  localparam logic [ADDR_W-1:0] OFF_STAT = 12'h328;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h340;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h344;
  localparam logic [CMP_COUNT-1:0] RST_PWR = 19'h00000;
  localparam logic [CMP_COUNT-1:0] RST_STAT = 19'h00000;
  localparam logic [CMP_COUNT-1:0] RST_MASK = 19'h00000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } cmplat_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } cmplat_rsp_t;

  typedef enum logic [1:0] {
    CMPLAT_IDLE,
    CMPLAT_DONE
  } cmplat_state_t;
endpackage

// ==== verif/cmplat_tb_top.sv ====
// Self-checking testbench for the comparator power and latch registers
`timescale 1ns/1ns
module cmplat_tb_top;
  import cmplat_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  cmplat_req_t bus_req = '0;
  cmplat_rsp_t bus_rsp;
  logic [CMP_COUNT-1:0] trip_in = '0;
  logic [CMP_COUNT-1:0] cmp_power_on;
  logic [CMP_COUNT-1:0] cmp_irq_level;
  logic irq;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] rd;

  always #25 clk_sys = ~clk_sys;

  cmplat_top u_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .trip_in(trip_in),
    .cmp_power_on(cmp_power_on),
    .cmp_irq_level(cmp_irq_level),
    .irq(irq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; waitrequest and readdata are read
  // at the rising edge, before the design updates them
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    bus_req.address <= a;
    bus_req.writedata <= d;
    bus_req.byteenable <= 4'hF;
    bus_req.write <= w;
    bus_req.read <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (bus_rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50) err_total++;
    rd = bus_rsp.readdata;
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pulse(input logic [CMP_COUNT-1:0] v);
    @(posedge clk_sys);
    trip_in <= v;
    @(posedge clk_sys);
    trip_in <= '0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic t_reset;
    rdchk(OFF_PWR, 32'h0);
    rdchk(OFF_STAT, 32'h0);
    rdchk(OFF_IRQ_MASK, 32'h0);
    @(negedge clk_sys);
    chk({13'h0, cmp_power_on}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
  endtask

  // Reserved upper bits must not stick, lower ones drive the run outputs
  task automatic t_power;
    bus(1'b1, OFF_PWR, 32'hFFFA_AAAA);
    rdchk(OFF_PWR, 32'h0002_AAAA);
    repeat (2) @(negedge clk_sys);
    chk({13'h0, cmp_power_on}, 32'h0002_AAAA);
    pulse(19'h00001);
    rdchk(OFF_STAT, 32'h0);
    bus(1'b1, OFF_PWR, 32'hFFFF_FFFF);
    rdchk(OFF_PWR, 32'h0007_FFFF);
  endtask

  task automatic t_latch;
    pulse(19'h7FFFF);
    rdchk(OFF_STAT, 32'h0007_FFFF);
    bus(1'b1, OFF_STAT, 32'h0000_0F0F);
    rdchk(OFF_STAT, 32'h0007_F0F0);
    bus(1'b1, OFF_STAT, 32'h0000_0000);
    repeat (5) @(posedge clk_sys);
    rdchk(OFF_STAT, 32'h0007_F0F0);
    @(negedge clk_sys);
    chk({13'h0, cmp_irq_level}, 32'h0007_F0F0);
    @(posedge clk_sys);
    bus(1'b1, OFF_STAT, 32'hFFF8_00F0);
    rdchk(OFF_STAT, 32'h0007_F000);
    bus(1'b1, OFF_STAT, 32'hFFFF_FFFF);
    rdchk(OFF_STAT, 32'h0);
  endtask

  task automatic t_irq;
    rdchk(OFF_IRQ_STATUS, 32'h0007_FFFF);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    bus(1'b1, OFF_IRQ_MASK, 32'h0000_0020);
    pulse(19'h00040);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    pulse(19'h00020);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk_sys);
    rdchk(OFF_IRQ_STATUS, 32'h0000_0060);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    // A fresh trip is only seen after the latch was cleared
    bus(1'b1, OFF_STAT, 32'h0000_0060);
    pulse(19'h00020);
    rdchk(OFF_STAT, 32'h0000_0020);
  endtask

  task automatic t_unmapped;
    bus(1'b1, 12'h100, 32'h1234_5678);
    rdchk(12'h100, UNMAPPED_DATA);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    give_verdict;
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_power;
    t_latch;
    t_irq;
    t_unmapped;
    give_verdict;
  end
endmodule // cmplat_tb_top
